// *** external_memory_port_defines.svh ***
// Register offsets, field positions, reset values and decode constants.
`ifndef EXTERNAL_MEMORY_PORT_DEFINES_SVH
`define EXTERNAL_MEMORY_PORT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the APB side
// ----------------------------------------------------------------------
`define XM_OFF_CTRL_A   12'h074
`define XM_OFF_CTRL_B   12'h078
`define XM_OFF_PORT     12'h07c
`define XM_OFF_STATUS   12'h080

// ----------------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------------
`define XM_A_EN         7
`define XM_A_LIM        6:4
`define XM_A_UWAIT      3:2
`define XM_A_LWAIT      1:0

// ----------------------------------------------------------------------
// Control B fields
// ----------------------------------------------------------------------
`define XM_B_KEEP       7
`define XM_B_MASK       2:0

// ----------------------------------------------------------------------
// Port register fields
// ----------------------------------------------------------------------
`define XM_P_LO_OUT     7:0
`define XM_P_LO_DIR     15:8
`define XM_P_HI_OUT     23:16
`define XM_P_HI_DIR     31:24

// ----------------------------------------------------------------------
// Reset values and decode constants
// ----------------------------------------------------------------------
`define XM_CTRL_RST     8'h00
`define XM_PORT_RST     32'h0000_0000
`define XM_INT_TOP      16'h2200
`define XM_LIM_MIN      3'h2
`define XM_LIM_PAD      13'h0000
`define XM_WAIT_LAST    2'h0
`define XM_WAIT_STEP    2'h1
`define XM_LEN_STEP     3'h1
`define XM_MASK_NONE    3'h0
`define XM_HI_BITS      4'h8
`define XM_TOP_PIN      4'h7
`define XM_ADDR_HI      15:8

`endif

// *** external_memory_port_pkg.sv ***
// Types shared by the external memory bus interface.
package external_memory_port_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_LATCH,
        ST_STROBE
    } bus_state_e;

    typedef struct packed {
        bus_state_e  st;
        logic [7:0]  ctl_a;
        logic [7:0]  ctl_b;
        logic [31:0] port;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        ext;
        logic [1:0]  wcode;
        logic [1:0]  wait_cnt;
        logic        ale;
        logic        rd_n;
        logic        wr_n;
        logic        ad_drv;
        logic [7:0]  ad_val;
        logic [7:0]  keep_val;
        logic [7:0]  rd_byte;
        logic        done;
        logic        apb_ld;
        logic [31:0] prdata;
        logic        pslverr;
    } external_memory_port_state_s;

endpackage : external_memory_port_pkg

// *** sector_wait_select.sv ***
// Sector decode: picks the wait code and flags external addresses.
`timescale 1ns/100ps
`include "external_memory_port_defines.svh"

module sector_wait_select (
    // Access address
    input  wire logic [15:0] addr,
    // Sector configuration
    input  wire logic [2:0]  limit,
    input  wire logic [1:0]  upper_wait,
    input  wire logic [1:0]  lower_wait,
    // Result
    output logic      [1:0]  wait_code,
    output logic             external
);

    logic [15:0] boundary;
    logic        upper;

    // Limits below the minimum code leave one sector covering everything.
    assign boundary  = {limit, `XM_LIM_PAD};
    assign upper     = (limit < `XM_LIM_MIN) || (addr >= boundary);
    assign wait_code = upper ? upper_wait : lower_wait;
    assign external  = (addr >= `XM_INT_TOP);

endmodule : sector_wait_select

// *** external_memory_bus_interface.sv ***
// External memory bus interface: APB registers, bus sequencer and pins.
`timescale 1ns/100ps
`include "external_memory_port_defines.svh"

module external_memory_bus_interface
    import external_memory_port_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Data-space access from the core
    input  wire logic        acc_valid,
    input  wire logic [15:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic        acc_next_ram,
    output logic             acc_ready,
    output logic             acc_done,
    output logic      [7:0]  acc_rdata,
    // Multiplexed low address and data bus
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  ad_out,
    output logic      [7:0]  ad_oe_n,
    output logic      [7:0]  ad_pullup_en,
    output logic             ad_keep_en,
    output logic      [7:0]  ad_keep_val,
    // High address byte
    output logic      [7:0]  ha_out,
    output logic      [7:0]  ha_oe_n,
    // Strobes
    output logic             ale,
    output logic             rd_n,
    output logic             wr_n
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    external_memory_port_state_s s_ff;
    external_memory_port_state_s nxt_s;

    logic        en;
    logic        apb_fire;
    logic        hit;
    logic [31:0] rd_mux;
    logic [1:0]  sel_wait;
    logic        sel_ext;
    logic [7:0]  released;

    assign en = s_ff.ctl_a[`XM_A_EN];

    sector_wait_select u_sector (
        .addr       (acc_addr),
        .limit      (s_ff.ctl_a[`XM_A_LIM]),
        .upper_wait (s_ff.ctl_a[`XM_A_UWAIT]),
        .lower_wait (s_ff.ctl_a[`XM_A_LWAIT]),
        .wait_code  (sel_wait),
        .external   (sel_ext)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle so prdata comes from a flop;
    // the cost is that pready waits one cycle if ce was low at setup.
    assign pready   = psel & penable & s_ff.apb_ld & ce;
    assign apb_fire = pready;
    assign prdata   = s_ff.prdata;
    assign pslverr  = s_ff.pslverr;

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `XM_OFF_CTRL_A: rd_mux = {24'h00_0000, s_ff.ctl_a};
            `XM_OFF_CTRL_B: rd_mux = {24'h00_0000, s_ff.ctl_b};
            `XM_OFF_PORT:   rd_mux = s_ff.port;
            `XM_OFF_STATUS: rd_mux = {s_ff.addr, s_ff.rd_byte, 5'h00,
                                      (s_ff.st != ST_IDLE), s_ff.st};
            default:        hit    = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;

        if (psel && !s_ff.apb_ld) begin
            nxt_s.apb_ld  = 1'b1;
            nxt_s.prdata  = rd_mux;
            nxt_s.pslverr = !hit;
        end
        if (apb_fire) begin
            nxt_s.apb_ld = 1'b0;
            if (pwrite) begin
                if (paddr == `XM_OFF_CTRL_A) begin
                    nxt_s.ctl_a = pwdata[7:0];
                end
                if (paddr == `XM_OFF_CTRL_B) begin
                    nxt_s.ctl_b = pwdata[7:0];
                end
                if (paddr == `XM_OFF_PORT) begin
                    nxt_s.port = pwdata;
                end
            end
        end

        if (s_ff.ad_drv) begin
            nxt_s.keep_val = s_ff.ad_val;
        end

        unique case (s_ff.st)
            ST_IDLE: begin
                nxt_s.ale = 1'b0;
                if (acc_valid && en) begin
                    nxt_s.st       = ST_ADDR;
                    nxt_s.addr     = acc_addr;
                    nxt_s.write    = acc_write;
                    nxt_s.wdata    = acc_wdata;
                    nxt_s.ext      = sel_ext;
                    nxt_s.wcode    = sel_wait;
                    nxt_s.wait_cnt = sel_wait;
                    nxt_s.ale      = 1'b1;
                    nxt_s.ad_drv   = 1'b1;
                    nxt_s.ad_val   = acc_addr[7:0];
                end
            end
            ST_ADDR: begin
                // Latch closes while the address is still on the bus.
                nxt_s.ale = 1'b0;
                nxt_s.st  = ST_LATCH;
            end
            ST_LATCH: begin
                if (!s_ff.ext) begin
                    // Internal access: pins show activity, no strobes.
                    nxt_s.st   = ST_IDLE;
                    nxt_s.done = 1'b1;
                    nxt_s.ale  = acc_next_ram;
                end else begin
                    nxt_s.st = ST_STROBE;
                    if (s_ff.write) begin
                        nxt_s.ad_val = s_ff.wdata;
                        nxt_s.wr_n   = 1'b0;
                    end else begin
                        nxt_s.ad_drv = 1'b0;
                        nxt_s.rd_n   = 1'b0;
                    end
                end
            end
            ST_STROBE: begin
                if (s_ff.wait_cnt == `XM_WAIT_LAST) begin
                    nxt_s.st     = ST_IDLE;
                    nxt_s.rd_n   = 1'b1;
                    nxt_s.wr_n   = 1'b1;
                    nxt_s.ad_drv = 1'b0;
                    nxt_s.done   = 1'b1;
                    nxt_s.ale    = acc_next_ram;
                    if (!s_ff.write) begin
                        nxt_s.rd_byte = ad_in;
                    end
                end else begin
                    nxt_s.wait_cnt = s_ff.wait_cnt - `XM_WAIT_STEP;
                end
            end
        endcase

        // Dropping the enable mid-access abandons it and hands pins back.
        if (!en) begin
            nxt_s.st     = ST_IDLE;
            nxt_s.ale    = 1'b0;
            nxt_s.rd_n   = 1'b1;
            nxt_s.wr_n   = 1'b1;
            nxt_s.ad_drv = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_ff          <= '0;
            s_ff.st       <= ST_IDLE;
            s_ff.ctl_a    <= `XM_CTRL_RST;
            s_ff.ctl_b    <= `XM_CTRL_RST;
            s_ff.port     <= `XM_PORT_RST;
            s_ff.rd_n     <= 1'b1;
            s_ff.wr_n     <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Core side and pins
    // ------------------------------------------------------------------
    assign acc_ready = (s_ff.st == ST_IDLE) & en;
    assign acc_done  = s_ff.done;
    assign acc_rdata = s_ff.rd_byte;

    assign ale  = en & s_ff.ale;
    assign rd_n = ~en | s_ff.rd_n;
    assign wr_n = ~en | s_ff.wr_n;

    // Keeper only acts while the sequencer has let go of the lines.
    assign ad_keep_en  = en & s_ff.ctl_b[`XM_B_KEEP] & ~s_ff.ad_drv;
    assign ad_keep_val = s_ff.keep_val;

    logic [7:0]  lo_dir;
    logic [7:0]  hi_out;
    logic [7:0]  hi_dir;
    logic [7:0]  hi_addr;

    assign lo_dir  = s_ff.port[`XM_P_LO_DIR];
    assign hi_out  = s_ff.port[`XM_P_HI_OUT];
    assign hi_dir  = s_ff.port[`XM_P_HI_DIR];
    assign hi_addr = s_ff.addr[`XM_ADDR_HI];

    genvar gi;
    generate
        for (gi = 0; gi < `XM_HI_BITS; gi = gi + 1) begin : g_pin
            logic lo_drv;
            assign lo_drv = en ? s_ff.ad_drv : lo_dir[gi];
            assign ad_out[gi]  = en ? s_ff.ad_val[gi]
                                    : s_ff.port[gi];
            assign ad_oe_n[gi] = ~lo_drv;
            assign ad_pullup_en[gi] = s_ff.port[gi] & ~lo_drv;
            // Mask code n frees the n most significant address pins.
            assign released[gi] = ({1'b0, s_ff.ctl_b[`XM_B_MASK]}
                                   > (`XM_TOP_PIN - 4'(gi)))
                                  && (s_ff.ctl_b[`XM_B_MASK]
                                      != `XM_MASK_NONE);
            assign ha_out[gi]  = (en && !released[gi])
                                 ? hi_addr[gi]
                                 : hi_out[gi];
            assign ha_oe_n[gi] = (en && !released[gi])
                                 ? 1'b0 : ~hi_dir[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [2:0] strobe_len_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strobe_len_ff <= 3'h0;
        end else if (ce) begin
            strobe_len_ff <= (!s_ff.rd_n || !s_ff.wr_n)
                             ? strobe_len_ff + `XM_LEN_STEP : 3'h0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_strobe_ext_only: assert property (
        (!rd_n || !wr_n) |-> s_ff.ext && (s_ff.addr >= `XM_INT_TOP))
        else $error("strobe asserted for an internal address");
    a_addr_at_fall: assert property (
        ce && s_ff.st == ST_ADDR && en |=> !ale && ad_oe_n == 8'h00
            && ad_out == s_ff.addr[7:0])
        else $error("address not on bus when latch falls");
    a_keeper_tracks: assert property (
        ce && s_ff.ad_drv |=> ad_keep_val == $past(s_ff.ad_val))
        else $error("keeper lost last driven value");
    a_wait_length: assert property (
        s_ff.st == ST_STROBE && s_ff.wait_cnt == `XM_WAIT_LAST
            |-> strobe_len_ff == {1'b0, s_ff.wcode})
        else $error("strobe length does not match wait code");
    a_sector_pick: assert property (
        ce && acc_ready && acc_valid |=> s_ff.wcode == $past(sel_wait))
        else $error("wait code not taken from sector");
    a_tail_pulse: assert property (
        ce && en && s_ff.st == ST_STROBE && s_ff.wait_cnt == `XM_WAIT_LAST
            |=> (ale == $past(acc_next_ram)) && rd_n && wr_n)
        else $error("trailing latch pulse wrong");
    a_mask_release: assert property (
        s_ff.ctl_b[`XM_B_MASK] != `XM_MASK_NONE
            |-> ha_out[7] == s_ff.port[23])
        else $error("masked high pin not given to port");
    a_disabled_port: assert property (
        !en |-> !ale && rd_n && wr_n && ad_out == s_ff.port[7:0])
        else $error("pins not returned to port when disabled");
    a_full_addr: assert property (
        en && s_ff.ctl_b[`XM_B_MASK] == `XM_MASK_NONE
            && s_ff.st != ST_IDLE |-> ha_out == s_ff.addr[15:8])
        else $error("high address byte altered");
    a_pullup_off: assert property (
        en && s_ff.ad_drv |-> ad_pullup_en == 8'h00 && !ad_keep_en)
        else $error("pull-up or keeper active while driving");

    c_ext_write: cover property (
        s_ff.st == ST_STROBE && !wr_n && s_ff.wcode == 2'h3);
    c_ext_read:  cover property (s_ff.st == ST_STROBE && !rd_n);
    c_int_acc:   cover property (s_ff.st == ST_LATCH && !s_ff.ext);
    c_tail:      cover property (s_ff.st == ST_IDLE && ale);

endmodule : external_memory_bus_interface

// *** ext_sram_model.sv ***
// Behavioural SRAM behind an address latch, with bus level resolution.
`timescale 1ns/100ps

module ext_sram_model (
    // Clock and speed select
    input  wire logic       clk_sys,
    input  wire logic       slow,
    // Pins of the interface
    input  wire logic [7:0] ad_out,
    input  wire logic [7:0] ad_oe_n,
    input  wire logic [7:0] ad_pullup_en,
    input  wire logic       ad_keep_en,
    input  wire logic [7:0] ad_keep_val,
    input  wire logic [7:0] ha_out,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    // Resolved bus level
    output logic      [7:0] ad_in
);
    logic [7:0]  mem [0:32767];
    logic [7:0]  lat;
    logic [7:0]  last;
    logic [1:0]  rd_cnt;
    logic [14:0] idx;
    logic        drv;

    // The top address line is left unwired, so upper addresses alias.
    assign idx = {ha_out[6:0], lat};
    // Data follows the strobe level only; a slow part needs one cycle.
    assign drv = !rd_n && (!slow || rd_cnt != 2'h0);

    always @(negedge ale) begin
        lat <= ad_in;
    end

    always @(posedge clk_sys) begin
        last <= ad_in;
        rd_cnt <= rd_n ? 2'h0 : rd_cnt + 2'h1;
        if (!wr_n) begin
            mem[idx] <= ad_in;
        end
    end

    // Lines with no driver, keeper or pull-up show the inverse of their last level, never a guess.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!ad_oe_n[i]) ad_in[i] = ad_out[i];
            else if (drv) ad_in[i] = mem[idx][i];
            else if (ad_keep_en) ad_in[i] = ad_keep_val[i];
            else if (ad_pullup_en[i]) ad_in[i] = 1'b1;
            else ad_in[i] = ~last[i];
        end
    end
endmodule : ext_sram_model

// *** test_external_memory_bus_interface.sv ***
// Self-checking bench for the external memory bus interface.
`timescale 1ns/100ps
`include "external_memory_port_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
    end end

module test_external_memory_bus_interface;
    logic        clk_sys = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, slow, ce;
    logic        acc_valid, acc_write, acc_next_ram, acc_ready, acc_done;
    logic        ad_keep_en, ale, rd_n, wr_n, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [15:0] acc_addr;
    logic [7:0]  acc_wdata, acc_rdata, ad_in, ad_out, ad_oe_n, bv;
    logic [7:0]  ad_pullup_en, ad_keep_val, ha_out, ha_oe_n;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #10 clk_sys = ~clk_sys;

    external_memory_bus_interface dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_wdata(acc_wdata),
        .acc_next_ram(acc_next_ram), .acc_ready(acc_ready),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_pullup_en(ad_pullup_en),
        .ad_keep_en(ad_keep_en), .ad_keep_val(ad_keep_val),
        .ha_out(ha_out), .ha_oe_n(ha_oe_n), .ale(ale), .rd_n(rd_n),
        .wr_n(wr_n));

    ext_sram_model ram_u (.clk_sys(clk_sys), .slow(slow), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .ad_pullup_en(ad_pullup_en),
        .ad_keep_en(ad_keep_en), .ad_keep_val(ad_keep_val),
        .ha_out(ha_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .ad_in(ad_in));

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // The whole run needs well under two thousand cycles.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only pready or the bench timeout may end this wait.
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One core access; ext, w, kp and ha give what the bus should show.
    task automatic acc(input logic [15:0] a, input logic wr,
        input logic [7:0] wd, input logic nr, input logic ext,
        input logic [1:0] w, input logic kp, input logic [7:0] ha);
        int n;
        int sl;
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_write <= wr;
        acc_wdata <= wd;
        acc_next_ram <= nr;
        @(negedge clk_sys);
        while (acc_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        n = 0;
        sl = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (rd_n !== 1'b1 || wr_n !== 1'b1) sl++;
            if (n == 1) `CHK(ale, 1'b1)
            if (ext && n == 2) begin
                `CHK(ale, 1'b0)
                `CHK(ad_out, a[7:0])
                `CHK(ad_oe_n, 8'h00)
                `CHK(ha_out, ha)
            end
            if (ext && !wr && n == 3) begin
                `CHK(ad_oe_n, 8'hff)
                `CHK(ad_keep_en, kp)
                if (kp) `CHK(ad_keep_val, a[7:0])
            end
        end while (acc_done !== 1'b1 && n < 40);
        `CHK(n, ext ? 4 + int'(w) : 3)
        `CHK(sl, ext ? 1 + int'(w) : 0)
        `CHK(ale, nr)
        bv = acc_rdata;
    endtask : acc

    task automatic t_reset;
        @(negedge clk_sys);
        `CHK({ale, rd_n, wr_n, acc_ready}, 4'b0110)
        `CHK({ad_oe_n, ha_oe_n}, 16'hffff)
        apb(1'b0, `XM_OFF_CTRL_A, 32'h0);
        `CHK(rv, 32'h0)
        apb(1'b1, `XM_OFF_CTRL_A, 32'h0000_007b);
        apb(1'b0, `XM_OFF_CTRL_A, 32'h0);
        `CHK(rv, 32'h0000_007b)
        apb(1'b1, 12'h100, 32'h0000_00ff);
        `CHK(ev, 1'b1)
        // Port mode: low dir 0f, out a5; high dir ff, out 3c.
        apb(1'b1, `XM_OFF_PORT, 32'hff3c_0fa5);
        @(negedge clk_sys);
        `CHK(ad_oe_n, 8'hf0)
        `CHK(ad_out & 8'h0f, 8'h05)
        `CHK(ad_pullup_en, 8'ha0)
        `CHK({ha_out, ha_oe_n}, 16'h3c00)
    endtask : t_reset

    // A low clock enable must hold off both the APB answer and the write.
    task automatic t_freeze;
        @(posedge clk_sys);
        ce <= 1'b0;
        fork
            apb(1'b1, `XM_OFF_PORT, 32'hff3c_0f5a);
            begin
                repeat (4) @(posedge clk_sys);
                `CHK({pready, ad_out & 8'h0f}, 9'h005)
                ce <= 1'b1;
            end
        join
        @(negedge clk_sys);
        `CHK(ad_out & 8'h0f, 8'h0a)
    endtask : t_freeze

    task automatic t_sectors;
        apb(1'b1, `XM_OFF_CTRL_B, 32'h0000_0080);
        for (int w = 0; w < 4; w++) begin
            // Limit 010 splits the space at 0x4000.
            apb(1'b1, `XM_OFF_CTRL_A, 32'ha0 | (w << 2) | (3 - w));
            slow <= (w != 0);
            acc(16'(16'h4100 + w), 1'b1, 8'(8'h30 + w), w[0], 1'b1,
                2'(w), 1'b1, 8'h41);
            acc(16'(16'h4100 + w), 1'b0, 8'h00, ~w[0], 1'b1, 2'(w),
                1'b1, 8'h41);
            `CHK(bv, 8'(8'h30 + w))
            // A slow part is only paired with a nonzero wait code.
            slow <= (w != 3);
            acc(16'(16'h2300 + w), 1'b1, 8'(8'hc0 + w), 1'b1, 1'b1,
                2'(3 - w), 1'b1, 8'h23);
            acc(16'(16'h2300 + w), 1'b0, 8'h00, 1'b0, 1'b1, 2'(3 - w),
                1'b1, 8'h23);
            `CHK(bv, 8'(8'hc0 + w))
        end
    endtask : t_sectors

    task automatic t_map;
        acc(16'h21ff, 1'b1, 8'h11, 1'b1, 1'b0, 2'h0, 1'b0, 8'h00);
        acc(16'h2200, 1'b1, 8'h22, 1'b0, 1'b1, 2'h0, 1'b0, 8'h22);
        `CHK(ram_u.mem[15'h2200], 8'h22)
        apb(1'b1, `XM_OFF_CTRL_A, 32'h0000_008d);
        // Limit 000 leaves one sector, so 0x2200 takes the upper wait.
        acc(16'h2200, 1'b0, 8'h00, 1'b0, 1'b1, 2'h3, 1'b1, 8'h22);
        `CHK(bv, 8'h22)
        acc(16'h8100, 1'b1, 8'h5a, 1'b0, 1'b1, 2'h3, 1'b0, 8'h81);
        `CHK(ram_u.mem[15'h0100], 8'h5a)
        apb(1'b1, `XM_OFF_CTRL_B, 32'h0000_0002);
        apb(1'b1, `XM_OFF_PORT, 32'hff00_0000);
        acc(16'h4001, 1'b1, 8'haa, 1'b0, 1'b1, 2'h3, 1'b0, 8'h00);
        acc(16'h4001, 1'b0, 8'h00, 1'b1, 1'b1, 2'h3, 1'b0, 8'h00);
        `CHK(bv, 8'haa)
        `CHK(ram_u.mem[15'h0001], 8'haa)
        apb(1'b1, `XM_OFF_CTRL_B, 32'h0);
        acc(16'h4001, 1'b1, 8'h55, 1'b0, 1'b1, 2'h3, 1'b0, 8'h40);
        `CHK(ram_u.mem[15'h4001], 8'h55)
        // Disable, then clear the pull-ups as before sleep.
        apb(1'b1, `XM_OFF_CTRL_A, 32'h0);
        apb(1'b1, `XM_OFF_PORT, 32'h0000_0f00);
        @(negedge clk_sys);
        `CHK({ad_oe_n, ad_pullup_en}, 16'hf000)
        `CHK({acc_ready, ha_oe_n}, 9'h0ff)
    endtask : t_map

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr = 16'h0000;
        acc_wdata = 8'h00;
        acc_next_ram = 1'b0;
        slow = 1'b0;
        ce = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_freeze();
        t_sectors();
        acc(16'h1000, 1'b0, 8'h00, 1'b1, 1'b0, 2'h0, 1'b0, 8'h00);
        t_map();
        wrap_up();
    end
endmodule : test_external_memory_bus_interface
